/* src/dpw_watchdog_top.sv */
// Dual process data watchdog with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Two independent watchdogs: network traffic and local interface traffic.
// - Network watchdog timeout defaults to 100 ms.
// - Local interface watchdog timeout defaults to 100 ms.
// - Each successful network process data exchange restarts the network count.
// - Enabled network watchdog expiring forces all outputs to false.
// - Expiry leaves the operational state untouched; only outputs change.
// - Tripped network watchdog stays tripped until next successful exchange or until it is disabled.
// - Enabled local watchdog trips after silence on the local interface.
// - Timeouts are software configurable, not fixed.
// - One tick lasts multiplier plus two periods of the 40 ns clock.
// - One shared multiplier; each watchdog has its own timeout count.
// - Network timeout value zero disables that watchdog completely.
// - Timeout accepts 0 to 65535; multiplier accepts 0 to 65535.
module dpw_watchdog_top (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_sys_rst,
   input  wire logic                      i_net_pd_ok,
   input  wire logic                      i_local_access,
   input  wire logic [dpw_pkg::OUT_W-1:0] i_proc_out,
   input  wire logic [dpw_pkg::STATE_W-1:0] i_run_state,
   output logic      [dpw_pkg::OUT_W-1:0] o_proc_out,
   output logic      [dpw_pkg::STATE_W-1:0] o_run_state,
   output logic                           o_net_tripped,
   output logic                           o_loc_tripped,
   output logic                           o_irq,
   input  wire logic [dpw_pkg::ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic                      i_s_axi_awvalid,
   output logic                           o_s_axi_awready,
   input  wire logic [31:0]               i_s_axi_wdata,
   input  wire logic [3:0]                i_s_axi_wstrb,
   input  wire logic                      i_s_axi_wvalid,
   output logic                           o_s_axi_wready,
   output logic [1:0]                     o_s_axi_bresp,
   output logic                           o_s_axi_bvalid,
   input  wire logic                      i_s_axi_bready,
   input  wire logic [dpw_pkg::ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic                      i_s_axi_arvalid,
   output logic                           o_s_axi_arready,
   output logic [31:0]                    o_s_axi_rdata,
   output logic [1:0]                     o_s_axi_rresp,
   output logic                           o_s_axi_rvalid,
   input  wire logic                      i_s_axi_rready
);
   import dpw_pkg::*;

   logic [TMO_W-1:0]  mult_q;
   logic [TMO_W-1:0]  tmo_q [NUM_WD];
   logic [NUM_WD-1:0] ctrl_q;
   logic [NUM_WD-1:0] irq_sts_q;
   logic [NUM_WD-1:0] irq_mask_q;
   logic [NUM_WD-1:0] tripped;
   logic [NUM_WD-1:0] expire;
   logic [NUM_WD-1:0] restart;
   logic [TMO_W:0]    tick_cnt_q;
   logic              tick;
   logic [OUT_W-1:0]  proc_out_q;
   logic [STATE_W-1:0] run_state_q;

   logic              aw_have_q;
   logic              w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              wr_go;
   logic [TMO_W-1:0]  wmask;
   logic [NUM_WD-1:0] w1c;

   // ---------------- Tick generator ----------------
   // Tick fires every mult+2 base cycles
   assign tick = (tick_cnt_q >= ({1'b0, mult_q} + 17'h0_0001));

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 17'h0_0001;
      end
   end

   // ---------------- Watchdogs ----------------
   assign restart[WD_NET] = i_net_pd_ok;
   assign restart[WD_LOC] = i_local_access;

   generate
      for (genvar g = 0; g < NUM_WD; g++) begin : g_wd
         // Shared tick, separate timeout per watchdog
         dpw_wd_timer u_timer (
            .i_core_clk (i_core_clk),
            .i_sys_rst  (i_sys_rst),
            .i_tick     (tick),
            .i_restart  (restart[g]),
            .i_enable   (ctrl_q[g]),
            .i_timeout  (tmo_q[g]),
            .o_tripped  (tripped[g]),
            .o_expire   (expire[g])
         );
      end
   endgenerate

   assign o_net_tripped = tripped[WD_NET];
   assign o_loc_tripped = tripped[WD_LOC];

   // ---------------- Outputs ----------------
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || tripped[WD_NET]) begin
         proc_out_q <= '0;
      end else begin
         proc_out_q <= i_proc_out;
      end
   end

   // Operational state is carried through, never touched by expiry
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         run_state_q <= '0;
      end else begin
         run_state_q <= i_run_state;
      end
   end

   assign o_proc_out  = proc_out_q;
   assign o_run_state = run_state_q;

   // ---------------- Interrupts ----------------
   assign o_irq = |(irq_sts_q & irq_mask_q);

   // Expiry beats a same-cycle write-one-to-clear
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         irq_sts_q <= '0;
      end else begin
         irq_sts_q <= (irq_sts_q & ~w1c) | expire;
      end
   end

   // ---------------- AXI4-Lite write ----------------
   assign o_s_axi_awready = !aw_have_q && !bvalid_q;
   assign o_s_axi_wready  = !w_have_q && !bvalid_q;
   assign o_s_axi_bvalid  = bvalid_q;
   assign o_s_axi_bresp   = bresp_q;
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign w1c   = (wr_go && (awaddr_q == REG_IRQ_STS) && wstrb_q[0]) ?
                  wdata_q[NUM_WD-1:0] : '0;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || wr_go) begin
         aw_have_q <= 1'b0;
      end else if (i_s_axi_awvalid && o_s_axi_awready) begin
         aw_have_q <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         awaddr_q <= '0;
      end else if (i_s_axi_awvalid && o_s_axi_awready) begin
         awaddr_q <= {i_s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || wr_go) begin
         w_have_q <= 1'b0;
      end else if (i_s_axi_wvalid && o_s_axi_wready) begin
         w_have_q <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (i_s_axi_wvalid && o_s_axi_wready) begin
         wdata_q <= i_s_axi_wdata;
         wstrb_q <= i_s_axi_wstrb;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         case (awaddr_q)
            REG_MULT, REG_NET_TMO, REG_LOC_TMO, REG_CTRL,
            REG_STATUS, REG_IRQ_STS, REG_IRQ_MASK: begin
               bresp_q <= RESP_OKAY;
            end
            default: begin
               bresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (i_s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ---------------- Configuration registers ----------------
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         mult_q <= MULT_RST;
      end else if (wr_go && (awaddr_q == REG_MULT)) begin
         mult_q <= (mult_q & ~wmask) | (wdata_q[TMO_W-1:0] & wmask);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         tmo_q[WD_NET] <= TMO_RST;
         tmo_q[WD_LOC] <= TMO_RST;
      end else if (wr_go && (awaddr_q == REG_NET_TMO)) begin
         tmo_q[WD_NET] <= (tmo_q[WD_NET] & ~wmask) | (wdata_q[TMO_W-1:0] & wmask);
      end else if (wr_go && (awaddr_q == REG_LOC_TMO)) begin
         tmo_q[WD_LOC] <= (tmo_q[WD_LOC] & ~wmask) | (wdata_q[TMO_W-1:0] & wmask);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_go && (awaddr_q == REG_CTRL) && wstrb_q[0]) begin
         ctrl_q <= wdata_q[NUM_WD-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         irq_mask_q <= MASK_RST;
      end else if (wr_go && (awaddr_q == REG_IRQ_MASK) && wstrb_q[0]) begin
         irq_mask_q <= wdata_q[NUM_WD-1:0];
      end
   end

   // ---------------- AXI4-Lite read ----------------
   assign o_s_axi_arready = !rvalid_q;
   assign o_s_axi_rvalid  = rvalid_q;
   assign o_s_axi_rdata   = rdata_q;
   assign o_s_axi_rresp   = rresp_q;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case ({i_s_axi_araddr[ADDR_W-1:2], 2'h0})
            REG_MULT:     rdata_q <= {16'h0000, mult_q};
            REG_NET_TMO:  rdata_q <= {16'h0000, tmo_q[WD_NET]};
            REG_LOC_TMO:  rdata_q <= {16'h0000, tmo_q[WD_LOC]};
            REG_CTRL:     rdata_q <= {30'h0000_0000, ctrl_q};
            REG_STATUS:   rdata_q <= {30'h0000_0000, tripped};
            REG_IRQ_STS:  rdata_q <= {30'h0000_0000, irq_sts_q};
            REG_IRQ_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
            default: begin
               rdata_q <= '0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (i_s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- Assertions ----------------
   logic [TMO_W:0] gap_q;
   logic           seen_tick_q;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         gap_q       <= '0;
         seen_tick_q <= 1'b0;
      end else if (tick) begin
         gap_q       <= 17'h0_0001;
         seen_tick_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 17'h0_0001;
      end
   end

   sequence s_net_trip;
      !tripped[WD_NET] ##1 tripped[WD_NET];
   endsequence

   sequence s_outputs_off;
      (o_proc_out == '0) [*2];
   endsequence

   a_outputs_forced: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_net_trip ##0 tripped[WD_NET] [*2] |-> s_outputs_off)
      else $error("outputs not forced off after network expiry");

   a_run_state_kept: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      tripped[WD_NET] ##1 1'b1 |-> o_run_state == $past(i_run_state))
      else $error("operational state altered");

   a_tick_period: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      tick && seen_tick_q && $stable(mult_q) |->
         gap_q == ({1'b0, mult_q} + 17'h0_0002))
      else $error("tick period is not multiplier plus two");

   a_reset_defaults: assert property (
      @(posedge i_core_clk)
      $past(i_sys_rst) |-> tmo_q[WD_NET] == TMO_RST && mult_q == MULT_RST)
      else $error("network timeout default wrong after reset");

   a_loc_default: assert property (
      @(posedge i_core_clk)
      $past(i_sys_rst) |-> tmo_q[WD_LOC] == TMO_RST)
      else $error("local timeout default wrong after reset");

   a_net_tmo_write: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      wr_go && awaddr_q == REG_NET_TMO && wstrb_q[1:0] == 2'h3 |=>
         tmo_q[WD_NET] == $past(wdata_q[TMO_W-1:0]))
      else $error("network timeout write not stored");

   a_net_restart: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      i_net_pd_ok |=> !o_net_tripped)
      else $error("exchange did not restart network watchdog");

   a_loc_expiry_flag: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      expire[WD_LOC] |=> o_loc_tripped && irq_sts_q[WD_LOC])
      else $error("local expiry not flagged");

   a_irq_level: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      expire[WD_NET] && irq_mask_q[WD_NET] && $stable(irq_mask_q) ##1
         $stable(irq_mask_q) |-> o_irq)
      else $error("masked-in expiry did not raise interrupt");
endmodule : dpw_watchdog_top
`default_nettype wire

/* src/dpw_pkg.sv */
// Constants shared by the dual process data watchdog
package dpw_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned WD_TICK_NS     = 100000;
   localparam int unsigned DEF_TIMEOUT_MS = 100;
   localparam int unsigned TICK_EXTRA     = 2;

   localparam int unsigned TMO_W   = 16;
   localparam int unsigned OUT_W   = 16;
   localparam int unsigned STATE_W = 4;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned NUM_WD  = 2;

   localparam logic [TMO_W-1:0] MULT_RST =
      TMO_W'(WD_TICK_NS / CLK_PERIOD_NS - TICK_EXTRA);
   localparam logic [TMO_W-1:0] TMO_RST =
      TMO_W'((DEF_TIMEOUT_MS * 1000000) / WD_TICK_NS);

   localparam logic [ADDR_W-1:0] REG_MULT     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_NET_TMO  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_LOC_TMO  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h10;
   localparam logic [ADDR_W-1:0] REG_IRQ_STS  = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;

   localparam int unsigned WD_NET = 0;
   localparam int unsigned WD_LOC = 1;

   localparam logic [NUM_WD-1:0] CTRL_RST = 2'h3;
   localparam logic [NUM_WD-1:0] MASK_RST = 2'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dpw_pkg

/* src/dpw_wd_timer.sv */
// One watchdog timer counting ticks since the last restart
`timescale 1ns/1ps
`default_nettype none
module dpw_wd_timer (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_tick,
   input  wire logic                     i_restart,
   input  wire logic                     i_enable,
   input  wire logic [dpw_pkg::TMO_W-1:0] i_timeout,
   output logic                          o_tripped,
   output logic                          o_expire
);
   import dpw_pkg::*;

   logic [TMO_W-1:0] cnt_q;
   logic             tripped_q;
   logic             active;
   logic [TMO_W:0]   cnt_inc;

   // Zero timeout disables the timer completely
   assign active  = i_enable && (i_timeout != '0);
   assign cnt_inc = {1'b0, cnt_q} + 17'h0_0001;
   // Restart beats an expiry landing on the same edge
   assign o_expire = active && i_tick && !tripped_q && !i_restart &&
                     (cnt_inc >= {1'b0, i_timeout});
   assign o_tripped = tripped_q;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || i_restart || !active) begin
         cnt_q <= '0;
      end else if (i_tick && (cnt_q != '1)) begin
         cnt_q <= cnt_inc[TMO_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || i_restart || !active) begin
         tripped_q <= 1'b0;
      end else if (o_expire) begin
         tripped_q <= 1'b1;
      end
   end

   a_trip_holds: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      tripped_q && !i_restart && active |=> tripped_q)
      else $error("tripped watchdog released without restart");

   a_restart_clears: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      i_restart |=> !tripped_q && (cnt_q == '0))
      else $error("restart did not clear the watchdog");

   a_zero_disables: assert property (
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_timeout == '0) |=> !tripped_q)
      else $error("watchdog tripped while disabled by zero timeout");
endmodule : dpw_wd_timer
`default_nettype wire

/* verif/dpw_far_model.sv */
// Far-side traffic source: network exchanges and local processor accesses
`timescale 1ns/1ps
`default_nettype none
module dpw_far_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_net_run,
   input  wire logic        i_loc_run,
   output logic             o_net_pd_ok,
   output logic             o_local_access,
   output logic [15:0]      o_proc_out,
   output logic [3:0]       o_run_state
);
   logic [15:0] cnt_q = 16'h0000;

   always @(posedge i_core_clk) begin
      cnt_q <= cnt_q + 16'h0001;
   end

   // One exchange every fourth cycle, well inside every timeout the bench sets
   assign o_net_pd_ok    = i_net_run & (cnt_q[1:0] == 2'h0);
   assign o_local_access = i_loc_run & (cnt_q[1:0] == 2'h2);
   // Output data changes every cycle so a stale or frozen copy shows up
   assign o_proc_out     = cnt_q ^ 16'h5A5A;
   assign o_run_state    = 4'h8;
endmodule : dpw_far_model
`default_nettype wire

/* verif/dpw_watchdog_top_tb.sv */
// Self-checking bench for the dual process data watchdog
`timescale 1ns/1ps
`default_nettype none
module dpw_watchdog_top_tb;
   import dpw_pkg::*;
   logic              clk, rst, net_run, loc_run, net_ok, loc_acc;
   logic [OUT_W-1:0]  pin, pout, pin_prev;
   logic [STATE_W-1:0] sin, sout, sin_prev;
   logic              net_trip, loc_trip, irq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   int                err_count, checks_done, net_idle, loc_idle;

   dpw_far_model far (.i_core_clk(clk), .i_net_run(net_run), .i_loc_run(loc_run),
      .o_net_pd_ok(net_ok), .o_local_access(loc_acc), .o_proc_out(pin), .o_run_state(sin));

   dpw_watchdog_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_net_pd_ok(net_ok),
      .i_local_access(loc_acc), .i_proc_out(pin), .i_run_state(sin), .o_proc_out(pout),
      .o_run_state(sout), .o_net_tripped(net_trip), .o_loc_tripped(loc_trip), .o_irq(irq),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cycles since the last exchange on each side, and last cycle's inputs
   always @(posedge clk) begin
      pin_prev <= pin;
      sin_prev <= sin;
      net_idle <= net_ok ? 0 : net_idle + 1;
      loc_idle <= loc_acc ? 0 : loc_idle + 1;
   end

   task automatic close_out();
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      b_hs = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!b_hs) begin
         @(negedge clk);
         aw_hs = awvalid & awready;
         w_hs = wvalid & wready;
         b_hs = (bvalid === 1'b1);
         r = bresp;
         @(posedge clk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk({29'h0, b_hs, r}, {29'h0, 1'b1, er}, "write response");
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      logic ar_hs, r_hs;
      logic [31:0] d;
      logic [1:0] r;
      r_hs = 1'b0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!r_hs) begin
         @(negedge clk);
         ar_hs = arvalid & arready;
         r_hs = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_hs) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk({29'h0, r_hs, r}, {29'h0, 1'b1, er}, "read response");
      chk(d, exp, "read data");
   endtask : rd

   // Waits for a trip, then checks how long that side had been silent
   task automatic wait_trip(input logic sel, input int lo, input int hi);
      int n;
      int idle;
      n = 0;
      while ((sel ? loc_trip : net_trip) !== 1'b1 && n < hi + 8) begin
         @(negedge clk);
         n++;
      end
      idle = sel ? loc_idle : net_idle;
      chk(32'(idle >= lo && idle <= hi), 32'h1, "trip moment");
   endtask : wait_trip

   task automatic chk_pass(input logic gated);
      @(negedge clk);
      chk(32'(pout), gated ? 32'h0 : 32'(pin_prev), "process outputs");
      chk(32'(sout), 32'(sin_prev), "state passthrough");
   endtask : chk_pass

   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end

   initial begin
      {rst, net_run, loc_run} = 3'b111;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      {err_count, checks_done, net_idle, loc_idle} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(REG_MULT, 32'(MULT_RST));
      rd(REG_NET_TMO, 32'(TMO_RST));
      rd(REG_LOC_TMO, 32'(TMO_RST));
      rd(REG_CTRL, 32'(CTRL_RST));
      rd(REG_IRQ_MASK, 32'(MASK_RST));
      rd(8'h1C, 32'h0000_0000, RESP_SLVERR);
      wr(8'h20, 32'h0000_0001, RESP_SLVERR);
      wr(REG_NET_TMO, 32'h0000_FFFF);
      rd(REG_NET_TMO, 32'h0000_FFFF);
      wr(REG_MULT, 32'h0000_FFFF);
      rd(REG_MULT, 32'h0000_FFFF);
      // Two-cycle ticks, short counts
      wr(REG_MULT, 32'h0000_0000);
      wr(REG_NET_TMO, 32'h0000_0004);
      wr(REG_LOC_TMO, 32'h0000_0006);
      repeat (40) @(negedge clk);
      chk({30'h0, loc_trip, net_trip}, 32'h0, "trip under traffic");
      chk_pass(1'b0);
      @(posedge clk);
      net_run <= 1'b0;
      wait_trip(1'b0, 7, 10);
      chk(32'(loc_trip), 32'h0, "local trip");
      chk_pass(1'b1);
      rd(REG_STATUS, 32'h0000_0001);
      rd(REG_IRQ_STS, 32'h0000_0001);
      @(negedge clk);
      chk(32'(irq), 32'h0, "masked irq");
      wr(REG_IRQ_MASK, 32'h0000_0001);
      @(negedge clk);
      chk(32'(irq), 32'h1, "unmasked irq");
      repeat (30) @(negedge clk);
      chk(32'(net_trip), 32'h1, "trip held");
      @(posedge clk);
      net_run <= 1'b1;
      repeat (8) @(negedge clk);
      chk(32'(net_trip), 32'h0, "trip cleared");
      chk_pass(1'b0);
      rd(REG_STATUS, 32'h0000_0000);
      wr(REG_IRQ_STS, 32'h0000_0001);
      rd(REG_IRQ_STS, 32'h0000_0000);
      @(negedge clk);
      chk(32'(irq), 32'h0, "irq cleared");
      // Local side alone
      @(posedge clk);
      loc_run <= 1'b0;
      wait_trip(1'b1, 11, 14);
      chk(32'(net_trip), 32'h0, "network trip");
      rd(REG_STATUS, 32'h0000_0002);
      loc_run <= 1'b1;
      repeat (8) @(posedge clk);
      rd(REG_STATUS, 32'h0000_0000);
      // Five-cycle ticks shared, counts differ
      wr(REG_MULT, 32'h0000_0003);
      wr(REG_NET_TMO, 32'h0000_0004);
      wr(REG_LOC_TMO, 32'h0000_0002);
      {net_run, loc_run} <= 2'b00;
      wait_trip(1'b1, 6, 12);
      wait_trip(1'b0, 16, 22);
      @(posedge clk);
      {net_run, loc_run} <= 2'b11;
      wr(REG_NET_TMO, 32'h0000_0000);
      net_run <= 1'b0;
      repeat (200) @(negedge clk);
      chk(32'(net_trip), 32'h0, "zero timeout");
      chk_pass(1'b0);
      close_out();
   end
endmodule : dpw_watchdog_top_tb
`default_nettype wire
